// File: rcb_buffer.sv
// Purpose: Reading capture buffer with size, source, group and pre-trigger control.
// Assumes: Reading strobes and trigger inputs are synchronous to sys_clk.
// Notes: Function
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module rcb_buffer (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port.
    input wire rcb_pkg::rcb_req_t busReq,
    output logic [31:0] busRdata,
    // Trigger model.
    input wire logic [16:0] measCount,
    input wire logic measCountInf,
    input wire logic pretrigEvent,
    // Reading sources.
    input wire rcb_pkg::rcb_reading_t senseReading,
    input wire logic senseValid,
    input wire rcb_pkg::rcb_reading_t calcReading,
    input wire logic calcValid,
    // Installed memory option.
    input wire logic [1:0] memOption,
    // Status.
    output logic storing
);
    rcb_pkg::rcb_entry_t mem [0:rcb_pkg::DEPTH-1];
    rcb_pkg::rcb_state_t stateReg, stateNext;
    logic [1:0] modeReg;
    logic element_group_select;
    logic [14:0] sizeReg, sizeNext;
    logic autoReg, autoNext;
    logic [1:0] feedReg;
    logic [6:0] pctReg;
    logic errReg;
    logic [14:0] ptrReg, ptrNext;
    logic firstReg, firstNext;
    logic [31:0] timerReg, baseReg, baseNext;
    logic [14:0] usedReg;
    logic [14:0] rdIndexReg;
    logic [31:0] rdMux;
    logic sizeErr;

    // The root-select address bit is not decoded, so both roots reach the same registers.
    wire [5:0] regOff = busReq.addr[rcb_pkg::OFF_W-1:0];
    wire wrAction = busReq.wr && regOff == rcb_pkg::OFF_ACTION;
    wire wrMode = busReq.wr && regOff == rcb_pkg::OFF_MODE;
    wire wrGroup = busReq.wr && regOff == rcb_pkg::OFF_ELEMENT_GROUP_SELECT;
    wire wrPoints = busReq.wr && regOff == rcb_pkg::OFF_POINTS;
    wire wrAuto = busReq.wr && regOff == rcb_pkg::OFF_AUTO;
    wire wrFeed = busReq.wr && regOff == rcb_pkg::OFF_FEED;
    wire wrPct = busReq.wr && regOff == rcb_pkg::OFF_PCT;
    wire wrRdIndex = busReq.wr && regOff == rcb_pkg::OFF_RD_INDEX;
    wire clearHit = wrAction && busReq.wdata[rcb_pkg::CLEAR_BIT];
    wire startHit = wrAction && busReq.wdata[rcb_pkg::START_BIT];
    wire abortHit = wrAction && busReq.wdata[rcb_pkg::ABORT_BIT];
    wire defHit = wrAction && busReq.wdata[rcb_pkg::SIZE_DEF_BIT];
    wire errClr = wrAction && busReq.wdata[rcb_pkg::ERR_BIT];
    wire sizeCmd = wrPoints || defHit || wrAuto;

    // Size limits by memory option and element group.
    wire [14:0] maxFull = memOption == rcb_pkg::OPT_MEM2 ? rcb_pkg::MAX_FULL_MEM2 :
        memOption == rcb_pkg::OPT_MEM1 ? rcb_pkg::MAX_FULL_MEM1 : rcb_pkg::MAX_FULL_NONE;
    wire [14:0] maxComp = memOption == rcb_pkg::OPT_MEM2 ? rcb_pkg::MAX_COMP_MEM2 :
        memOption == rcb_pkg::OPT_MEM1 ? rcb_pkg::MAX_COMP_MEM1 : rcb_pkg::MAX_COMP_NONE;
    wire [14:0] maxPoints = element_group_select == rcb_pkg::GROUP_COMPACT ? maxComp : maxFull;
    wire [14:0] wrSize = busReq.wdata[14:0];
    wire sizeOk = busReq.wdata[31:15] == '0 && wrSize >= rcb_pkg::SIZE_MIN && wrSize <= maxPoints;
    wire [16:0] maxWide = {2'b00, maxPoints};
    wire [16:0] minWide = {2'b00, rcb_pkg::SIZE_MIN};
    wire [14:0] autoTarget = measCount > maxWide ? maxPoints :
        measCount < minWide ? rcb_pkg::SIZE_MIN : measCount[14:0];
    wire pctOk = busReq.wdata[31:7] == '0 && busReq.wdata[6:0] <= rcb_pkg::PCT_MAX;

    // Reserved pre-trigger locations.
    wire [21:0] preProd = sizeReg * pctReg;
    wire [21:0] preQuot = preProd / {15'h0000, rcb_pkg::PCT_MAX};
    wire [14:0] preAmt = preQuot[14:0];
    wire [14:0] lastLoc = sizeReg - rcb_pkg::PTR_ONE;
    wire [14:0] preLast = preAmt - rcb_pkg::PTR_ONE;

    // Reading source selection.
    wire rcb_pkg::rcb_reading_t inReading = feedReg == rcb_pkg::calc_token ? calcReading : senseReading;
    wire inValid = feedReg == rcb_pkg::sense_token ? senseValid :
        feedReg == rcb_pkg::calc_token ? calcValid : 1'b0;
    wire phaseWrites = stateReg == rcb_pkg::ST_FILL || stateReg == rcb_pkg::ST_POST ||
        (stateReg == rcb_pkg::ST_PRE && preAmt != '0);
    wire doWrite = inValid && phaseWrites;
    wire startOk = startHit && modeReg != rcb_pkg::storage_disabled_mode &&
        feedReg != rcb_pkg::none_token;

    // Compact entries carry no stamp; the first of a run is the time origin.
    wire [31:0] stampNow = (element_group_select == rcb_pkg::GROUP_COMPACT || firstReg) ? '0 :
        timerReg - baseReg;
    wire rcb_pkg::rcb_entry_t newEntry = '{rd: inReading, loc: ptrReg, stamp: stampNow};
    wire [14:0] ptrInc = ptrReg + rcb_pkg::PTR_ONE;

    // Memory status in bytes.
    wire [23:0] bytesPer = element_group_select == rcb_pkg::GROUP_COMPACT ? rcb_pkg::BYTES_COMPACT :
        rcb_pkg::BYTES_FULL;
    wire [23:0] memBytes = {9'h000, maxFull} * rcb_pkg::BYTES_FULL;
    wire [23:0] usedBytes = {9'h000, usedReg} * bytesPer;
    wire [23:0] availBytes = memBytes - usedBytes;

    // Readout beyond the stored count shows zeros, which is how a cleared buffer reads.
    wire rdInRange = rdIndexReg < usedReg;
    wire rcb_pkg::rcb_entry_t rdEntry = rdInRange ? mem[rdIndexReg] : '0;

    always_comb begin
        case (regOff)
            rcb_pkg::OFF_ACTION: rdMux = {27'h0000000, errReg, stateReg};
            rcb_pkg::OFF_MODE: rdMux = {30'h00000000, modeReg};
            rcb_pkg::OFF_ELEMENT_GROUP_SELECT: rdMux = {31'h00000000, element_group_select};
            rcb_pkg::OFF_POINTS: rdMux = {17'h00000, sizeReg};
            rcb_pkg::OFF_AUTO: rdMux = {31'h00000000, autoReg};
            rcb_pkg::OFF_FEED: rdMux = {30'h00000000, feedReg};
            rcb_pkg::OFF_PCT: rdMux = {25'h0000000, pctReg};
            rcb_pkg::OFF_FREE_AVAIL: rdMux = {8'h00, availBytes};
            rcb_pkg::OFF_FREE_USED: rdMux = {8'h00, usedBytes};
            rcb_pkg::OFF_RD_INDEX: rdMux = {17'h00000, rdIndexReg};
            rcb_pkg::OFF_RD_VALUE: rdMux = rdEntry.rd.value;
            rcb_pkg::OFF_RD_META: rdMux = {9'h000, rdEntry.rd.func, rdEntry.rd.chan, rdEntry.loc};
            rcb_pkg::OFF_RD_TIME: rdMux = rdEntry.stamp;
            default: rdMux = '0;
        endcase
    end

    // Size and auto sizing; an explicit command always beats the follow path.
    always_comb begin
        sizeNext = sizeReg;
        autoNext = autoReg;
        sizeErr = 1'b0;
        if (wrPoints) begin
            if (sizeOk) begin
                sizeNext = wrSize;
                autoNext = 1'b0;
            end else begin
                sizeErr = 1'b1;
            end
        end else if (defHit) begin
            sizeNext = rcb_pkg::SIZE_DEF;
            autoNext = 1'b0;
        end else if (wrAuto) begin
            if (busReq.wdata[0]) begin
                if (measCountInf) begin
                    sizeErr = 1'b1;
                end else begin
                    autoNext = 1'b1;
                    sizeNext = autoTarget;
                end
            end else begin
                autoNext = 1'b0;
            end
        end else if (autoReg && !measCountInf) begin
            sizeNext = autoTarget;
        end
    end

    // Storage sequencing.
    always_comb begin
        stateNext = stateReg;
        ptrNext = ptrReg;
        firstNext = firstReg;
        baseNext = baseReg;
        if (doWrite) begin
            firstNext = 1'b0;
            if (firstReg) begin
                baseNext = timerReg;
            end
        end
        case (stateReg)
            rcb_pkg::ST_IDLE: begin
                ptrNext = ptrReg;
            end
            rcb_pkg::ST_FILL: begin
                if (doWrite) begin
                    if (ptrReg >= lastLoc) begin
                        ptrNext = '0;
                        if (modeReg != rcb_pkg::always_mode) begin
                            stateNext = rcb_pkg::ST_IDLE;
                        end
                    end else begin
                        ptrNext = ptrInc;
                    end
                end
            end
            rcb_pkg::ST_PRE: begin
                if (pretrigEvent) begin
                    ptrNext = preAmt;
                    stateNext = preAmt >= sizeReg ? rcb_pkg::ST_IDLE : rcb_pkg::ST_POST;
                end else if (doWrite) begin
                    ptrNext = ptrReg >= preLast ? '0 : ptrInc;
                end
            end
            rcb_pkg::ST_POST: begin
                if (doWrite) begin
                    if (ptrReg >= lastLoc) begin
                        stateNext = rcb_pkg::ST_IDLE;
                    end else begin
                        ptrNext = ptrInc;
                    end
                end
            end
            default: begin
                stateNext = rcb_pkg::ST_IDLE;
            end
        endcase
        if (startOk) begin
            stateNext = modeReg == rcb_pkg::capture_mode_a ? rcb_pkg::ST_PRE : rcb_pkg::ST_FILL;
            ptrNext = '0;
            firstNext = 1'b1;
        end else if (abortHit) begin
            stateNext = rcb_pkg::ST_IDLE;
        end
    end

    // The array has no reset; stale words stay hidden behind the stored count.
    always_ff @(posedge sys_clk) begin
        if (doWrite) begin
            mem[ptrReg] <= newEntry;
        end
    end

    // Settings return to defaults on rstn; the size-default action also resets the size and clears auto.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            modeReg <= rcb_pkg::storage_disabled_mode;
            element_group_select <= rcb_pkg::GROUP_FULL;
            sizeReg <= rcb_pkg::SIZE_DEF;
            autoReg <= 1'b0;
            feedReg <= rcb_pkg::none_token;
            pctReg <= rcb_pkg::PCT_DEF;
        end else begin
            sizeReg <= sizeNext;
            autoReg <= autoNext;
            if (wrMode) begin
                modeReg <= busReq.wdata[1:0];
            end
            if (wrGroup) begin
                element_group_select <= busReq.wdata[0];
            end
            if (wrFeed && busReq.wdata[1:0] != 2'h3) begin
                feedReg <= busReq.wdata[1:0];
            end
            if (wrPct && pctOk) begin
                pctReg <= busReq.wdata[6:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            stateReg <= rcb_pkg::ST_IDLE;
            ptrReg <= '0;
            firstReg <= 1'b1;
            baseReg <= '0;
            timerReg <= '0;
            rdIndexReg <= '0;
            busRdata <= '0;
        end else begin
            stateReg <= stateNext;
            ptrReg <= ptrNext;
            firstReg <= firstNext;
            baseReg <= baseNext;
            timerReg <= timerReg + 32'h00000001;
            busRdata <= busReq.rd ? rdMux : '0;
            if (wrRdIndex) begin
                rdIndexReg <= busReq.wdata[14:0];
            end
        end
    end

    // A write in the clear cycle sets the stored count to its location plus one, so no event is lost.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            usedReg <= '0;
            errReg <= 1'b0;
        end else begin
            if (clearHit) begin
                usedReg <= doWrite ? ptrInc : '0;
            end else if (doWrite && ptrInc > usedReg) begin
                usedReg <= ptrInc;
            end
            if (sizeErr || (wrPct && !pctOk)) begin
                errReg <= 1'b1;
            end else if (errClr) begin
                errReg <= 1'b0;
            end
        end
    end

    assign storing = stateReg != rcb_pkg::ST_IDLE;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_none_no_write: assert property (feedReg == rcb_pkg::none_token |-> !doWrite)
        else $error("Reading stored with source none.");
    a_auto_follow: assert property (autoReg && !measCountInf && !sizeCmd |=> sizeReg == $past(autoTarget))
        else $error("Auto size did not follow measure count.");
    a_points_auto_off: assert property (wrPoints && sizeOk |=> !autoReg && sizeReg == $past(wrSize))
        else $error("Explicit size did not take or auto stayed on.");
    a_auto_inf_err: assert property (wrAuto && busReq.wdata[0] && measCountInf && !autoReg |=> !autoReg && errReg)
        else $error("Auto enable with infinite count not refused.");
    a_auto_off_keep: assert property (wrAuto && !busReq.wdata[0] && autoReg |=> !autoReg && $stable(sizeReg))
        else $error("Disabling auto changed the size.");
    a_clear_empty: assert property (clearHit && !doWrite |=> usedReg == '0 && usedBytes == '0)
        else $error("Clear left readings counted.");
    a_post_start: assert property (stateReg == rcb_pkg::ST_PRE && pretrigEvent && !startHit && !abortHit
        |=> ptrReg == $past(preAmt))
        else $error("Post phase did not start after the reserve.");
    a_post_stop: assert property (stateReg == rcb_pkg::ST_POST && doWrite && ptrReg >= lastLoc && !startHit
        |=> stateReg == rcb_pkg::ST_IDLE)
        else $error("Storage did not stop at the last location.");
    a_pre_wrap: assert property (stateReg == rcb_pkg::ST_PRE && doWrite && ptrReg == preLast && !pretrigEvent
        && !startHit && !abortHit |=> ptrReg == '0)
        else $error("Pre phase pointer did not wrap.");
    a_size_range: assert property (sizeReg >= rcb_pkg::SIZE_MIN && sizeReg <= rcb_pkg::MAX_COMP_MEM2)
        else $error("Buffer size out of range.");
    a_first_stamp: assert property (doWrite && firstReg && !startOk
        |-> newEntry.stamp == '0 ##1 (!firstReg && baseReg == $past(timerReg)))
        else $error("First reading stamp not zero or time origin not taken.");
    // Default size, refusals, the sticky error flag, refused starts, the fill-once ending, the always wrap and the compact stamp.
    a_def_size: assert property (defHit |=> sizeReg == rcb_pkg::SIZE_DEF && !autoReg)
        else $error("Default size request did not give the default size.");
    a_pct_refuse: assert property (wrPct && !pctOk |=> $stable(pctReg) && errReg)
        else $error("Out of range percentage not refused.");
    a_feed_refuse: assert property (wrFeed && busReq.wdata[1:0] == 2'h3 |=> $stable(feedReg))
        else $error("Unknown source code changed the source.");
    a_err_sticky: assert property (errReg && !errClr |=> errReg)
        else $error("Error flag dropped without a clear.");
    a_storage_disabled_mode_idle: assert property (startHit && modeReg == rcb_pkg::storage_disabled_mode
        && stateReg == rcb_pkg::ST_IDLE |=> stateReg == rcb_pkg::ST_IDLE)
        else $error("Storage started while disabled.");
    a_none_no_start: assert property (startHit && feedReg == rcb_pkg::none_token
        && stateReg == rcb_pkg::ST_IDLE |=> stateReg == rcb_pkg::ST_IDLE)
        else $error("Storage started with source none.");
    a_fill_once_stop: assert property (stateReg == rcb_pkg::ST_FILL && modeReg == rcb_pkg::fill_once_mode
        && doWrite && ptrReg >= lastLoc && !startHit |=> stateReg == rcb_pkg::ST_IDLE)
        else $error("Fill-once run did not stop when full.");
    a_always_wrap: assert property (stateReg == rcb_pkg::ST_FILL && modeReg == rcb_pkg::always_mode
        && doWrite && ptrReg >= lastLoc && !startHit && !abortHit |=> stateReg == rcb_pkg::ST_FILL && ptrReg == '0)
        else $error("Always run did not wrap to the first location.");
    a_compact_stamp: assert property (element_group_select == rcb_pkg::GROUP_COMPACT && doWrite
        |-> newEntry.stamp == '0)
        else $error("Compact entry carries a stamp.");

    // Covers mark the storage runs and the auto sizing the bench is expected to reach.
    c_fill_done: cover property (stateReg == rcb_pkg::ST_FILL ##1 stateReg == rcb_pkg::ST_IDLE);
    c_pre_to_post: cover property (stateReg == rcb_pkg::ST_PRE ##1 stateReg == rcb_pkg::ST_POST);
    c_always_wrap: cover property (modeReg == rcb_pkg::always_mode && doWrite && ptrReg >= lastLoc);
    c_auto_on: cover property (!autoReg ##1 autoReg);
    c_compact_store: cover property (element_group_select == rcb_pkg::GROUP_COMPACT && doWrite);
endmodule : rcb_buffer

// File: rcb_host.sv
// Purpose: Host model that sends register writes and reads to the reading capture buffer.
// Assumes: One request at a time, every strobe one cycle long, changed just after a rising edge.
// Notes: Read data is taken only in the cycle after the read strobe.
`timescale 1ns/100ps
module rcb_host (
    // Clock.
    input wire logic sys_clk,
    // Register port.
    output rcb_pkg::rcb_req_t busReq,
    input wire logic [31:0] busRdata
);
    initial begin
        busReq = '0;
    end

    // The data lines are inverted after a write so stale data never looks valid.
    task automatic wr_reg(input logic [7:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        busReq <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
        busReq.wdata <= ~data;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] addr, output logic [31:0] data);
        @(posedge sys_clk);
        busReq <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
        #1;
        data = busRdata;
    endtask : rd_reg
endmodule : rcb_host

// File: rcb_pkg.sv
// Purpose: Shared constants and types for the reading capture buffer.
// Assumes: Register offsets are byte addresses of aligned 32-bit words.
// Notes: Tokens returned by queries are the small codes below.
package rcb_pkg;
    // Register port.
    localparam int ADDR_W = 8;
    localparam int OFF_W = 6;
    localparam logic [5:0] OFF_ACTION = 6'h00;
    localparam logic [5:0] OFF_MODE = 6'h04;
    localparam logic [5:0] OFF_ELEMENT_GROUP_SELECT = 6'h08;
    localparam logic [5:0] OFF_POINTS = 6'h0c;
    localparam logic [5:0] OFF_AUTO = 6'h10;
    localparam logic [5:0] OFF_FEED = 6'h14;
    localparam logic [5:0] OFF_PCT = 6'h18;
    localparam logic [5:0] OFF_FREE_AVAIL = 6'h1c;
    localparam logic [5:0] OFF_FREE_USED = 6'h20;
    localparam logic [5:0] OFF_RD_INDEX = 6'h24;
    localparam logic [5:0] OFF_RD_VALUE = 6'h28;
    localparam logic [5:0] OFF_RD_META = 6'h2c;
    localparam logic [5:0] OFF_RD_TIME = 6'h30;
    // Action register bits.
    localparam int CLEAR_BIT = 0;
    localparam int START_BIT = 1;
    localparam int ABORT_BIT = 2;
    localparam int SIZE_DEF_BIT = 3;
    localparam int ERR_BIT = 4;
    // Buffer control modes.
    localparam logic [1:0] storage_disabled_mode = 2'h0;
    localparam logic [1:0] fill_once_mode = 2'h1;
    localparam logic [1:0] always_mode = 2'h2;
    localparam logic [1:0] capture_mode_a = 2'h3;
    // Reading source tokens.
    localparam logic [1:0] none_token = 2'h0;
    localparam logic [1:0] sense_token = 2'h1;
    localparam logic [1:0] calc_token = 2'h2;
    // Element groups.
    localparam logic GROUP_FULL = 1'b0;
    localparam logic GROUP_COMPACT = 1'b1;
    // Sizes.
    localparam int LOC_W = 15;
    localparam int DEPTH = 30000;
    localparam logic [14:0] SIZE_MIN = 15'h0002;
    localparam logic [14:0] SIZE_DEF = 15'h0064;
    localparam logic [14:0] MAX_FULL_NONE = 15'h00fa;
    localparam logic [14:0] MAX_COMP_NONE = 15'h0352;
    localparam logic [14:0] MAX_FULL_MEM1 = 15'h0578;
    localparam logic [14:0] MAX_COMP_MEM1 = 15'h1b58;
    localparam logic [14:0] MAX_FULL_MEM2 = 15'h1770;
    localparam logic [14:0] MAX_COMP_MEM2 = 15'h7530;
    localparam logic [14:0] PTR_ONE = 15'h0001;
    localparam logic [1:0] OPT_MEM1 = 2'h1;
    localparam logic [1:0] OPT_MEM2 = 2'h2;
    localparam logic [6:0] PCT_DEF = 7'h32;
    localparam logic [6:0] PCT_MAX = 7'h64;
    // Storage cost per reading, in bytes.
    localparam logic [23:0] BYTES_FULL = 24'h000014;
    localparam logic [23:0] BYTES_COMPACT = 24'h000004;
    // Storage process states.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FILL = 4'h2,
        ST_PRE = 4'h4,
        ST_POST = 4'h8
    } rcb_state_t;
    typedef struct packed {
        logic [31:0] value;
        logic [3:0] func;
        logic [3:0] chan;
    } rcb_reading_t;
    typedef struct packed {
        rcb_reading_t rd;
        logic [14:0] loc;
        logic [31:0] stamp;
    } rcb_entry_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rcb_req_t;
endpackage : rcb_pkg

// File: test_reading_capture_buffer.sv
// Purpose: Self-checking bench for the reading capture buffer.
// Assumes: Memory option 2 is installed except for the no-option size checks; readings arrive on consecutive cycles.
// Notes: Settings are checked from a row table, storage runs by hand after it.
`timescale 1ns/100ps
module test_reading_capture_buffer;
    typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} rcb_row_t;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    rcb_pkg::rcb_req_t busReq;
    logic [31:0] busRdata;
    logic [16:0] measCount = 17'h00c8;
    logic measCountInf = 1'b0;
    logic pretrigEvent = 1'b0;
    rcb_pkg::rcb_reading_t senseReading = '0;
    logic senseValid = 1'b0;
    rcb_pkg::rcb_reading_t calcReading = '0;
    logic calcValid = 1'b0;
    logic [1:0] memOption = 2'h2;
    logic storing;
    logic [31:0] got;
    int fails = 0;
    int tests_run = 0;
    rcb_row_t rows[17];

    rcb_buffer rcb_buffer_i (.sys_clk(sys_clk), .rstn(rstn), .busReq(busReq), .busRdata(busRdata),
        .measCount(measCount), .measCountInf(measCountInf), .pretrigEvent(pretrigEvent),
        .senseReading(senseReading), .senseValid(senseValid), .calcReading(calcReading),
        .calcValid(calcValid), .memOption(memOption), .storing(storing));
    rcb_host rcb_host_i (.sys_clk(sys_clk), .busReq(busReq), .busRdata(busRdata));

    always #50 sys_clk = ~sys_clk;

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] seen);
        tests_run++;
        if (seen !== ex) begin
            $display("Error %s expected %h seen %h", what, ex, seen);
            fails++;
        end
    endtask : chk

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] ex);
        rcb_host_i.rd_reg(a, got);
        chk(what, ex, got);
    endtask : rdchk

    task automatic entry(input logic [14:0] idx, input logic [7:0] f, input logic [31:0] ex);
        rcb_host_i.wr_reg(8'h24, {17'h0, idx});
        rdchk("entry", f, ex);
    endtask : entry

    // Both sources carry the same word, so a wrong source choice still shows up as a missing entry.
    task automatic feed(input logic calc, input int n, input logic [31:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            senseValid <= !calc;
            calcValid <= calc;
            senseReading <= '{32'(base + i), 4'h3, 4'h5};
            calcReading <= '{32'(base + i), 4'h3, 4'h5};
        end
        @(posedge sys_clk);
        senseValid <= 1'b0;
        calcValid <= 1'b0;
    endtask : feed

    task automatic wait_idle;
        for (int i = 0; i < 60 && storing !== 1'b0; i++) @(posedge sys_clk);
        if (storing !== 1'b0) begin
            $display("Error storing expected 0 seen %b", storing);
            fails++;
            wrap_up();
        end else begin
            tests_run++;
        end
    endtask : wait_idle

    initial begin
        rows = '{'{8'h0c, 32'h32, 8'h0c, 32'h32}, '{8'h0c, 32'h1, 8'h0c, 32'h32},
            '{8'h0c, 32'h1771, 8'h0c, 32'h32}, '{8'h0c, 32'h2, 8'h0c, 32'h2},
            '{8'h4c, 32'h4b, 8'h0c, 32'h4b}, '{8'h18, 32'h19, 8'h18, 32'h19},
            '{8'h18, 32'h65, 8'h18, 32'h19}, '{8'h18, 32'h0, 8'h18, 32'h0},
            '{8'h08, 32'h1, 8'h48, 32'h1}, '{8'h08, 32'h0, 8'h08, 32'h0},
            '{8'h14, 32'h2, 8'h14, 32'h2}, '{8'h14, 32'h3, 8'h14, 32'h2},
            '{8'h14, 32'h1, 8'h14, 32'h1}, '{8'h04, 32'h3, 8'h04, 32'h3},
            '{8'h04, 32'h2, 8'h04, 32'h2}, '{8'h04, 32'h1, 8'h04, 32'h1},
            '{8'h04, 32'h0, 8'h04, 32'h0}};
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        rdchk("mode", 8'h04, 32'h0);
        rdchk("element_group_select", 8'h08, 32'h0);
        rdchk("points", 8'h0c, 32'h64);
        rdchk("auto", 8'h10, 32'h0);
        rdchk("feed", 8'h14, 32'h0);
        rdchk("pct", 8'h18, 32'h32);
        foreach (rows[i]) begin
            rcb_host_i.wr_reg(rows[i].wa, rows[i].wd);
            rdchk("row", rows[i].ra, rows[i].ex);
        end
        rcb_host_i.wr_reg(8'h10, 32'h1);
        rdchk("auto size", 8'h0c, 32'hc8);
        measCount <= 17'h012c;
        rdchk("auto follow", 8'h0c, 32'h12c);
        rcb_host_i.wr_reg(8'h10, 32'h0);
        measCount <= 17'h0190;
        rdchk("auto off", 8'h0c, 32'h12c);
        rcb_host_i.wr_reg(8'h10, 32'h1);
        rcb_host_i.wr_reg(8'h0c, 32'h3c);
        rdchk("explicit size", 8'h0c, 32'h3c);
        rdchk("auto cleared", 8'h10, 32'h0);
        rcb_host_i.wr_reg(8'h00, 32'h8);
        rdchk("size default", 8'h0c, 32'h64);
        memOption <= 2'h0;
        rcb_host_i.wr_reg(8'h0c, 32'hfb);
        rdchk("no option max", 8'h0c, 32'h64);
        rcb_host_i.wr_reg(8'h0c, 32'hfa);
        rdchk("no option size", 8'h0c, 32'hfa);
        memOption <= 2'h2;
        measCountInf <= 1'b1;
        rcb_host_i.wr_reg(8'h00, 32'h10);
        rcb_host_i.wr_reg(8'h10, 32'h1);
        rdchk("auto refused", 8'h10, 32'h0);
        rdchk("error flag", 8'h00, 32'h11);
        measCountInf <= 1'b0;
        rcb_host_i.wr_reg(8'h0c, 32'h4);
        rcb_host_i.wr_reg(8'h18, 32'h32);
        rcb_host_i.wr_reg(8'h14, 32'h0);
        rcb_host_i.wr_reg(8'h04, {30'h0, rcb_pkg::fill_once_mode});
        rcb_host_i.wr_reg(8'h00, 32'h3);
        feed(1'b0, 2, 32'h10);
        rdchk("none used", 8'h20, 32'h0);
        rcb_host_i.wr_reg(8'h14, 32'h1);
        rcb_host_i.wr_reg(8'h00, 32'h3);
        feed(1'b0, 4, 32'h10);
        wait_idle();
        rdchk("used", 8'h20, 32'h50);
        rdchk("avail", 8'h1c, 32'h1d470);
        entry(15'h0, 8'h30, 32'h0);
        entry(15'h3, 8'h30, 32'h3);
        entry(15'h2, 8'h2c, {9'h0, 4'h3, 4'h5, 15'h2});
        rcb_host_i.wr_reg(8'h00, 32'h2);
        feed(1'b0, 2, 32'h20);
        rcb_host_i.wr_reg(8'h00, 32'h4);
        entry(15'h0, 8'h28, 32'h20);
        entry(15'h3, 8'h28, 32'h13);
        rcb_host_i.wr_reg(8'h00, 32'h1);
        rdchk("cleared", 8'h20, 32'h0);
        entry(15'h0, 8'h28, 32'h0);
        rcb_host_i.wr_reg(8'h14, 32'h2);
        rcb_host_i.wr_reg(8'h04, {30'h0, rcb_pkg::capture_mode_a});
        rcb_host_i.wr_reg(8'h00, 32'h3);
        feed(1'b1, 5, 32'h30);
        pretrigEvent <= 1'b1;
        @(posedge sys_clk);
        pretrigEvent <= 1'b0;
        feed(1'b1, 3, 32'h40);
        wait_idle();
        entry(15'h0, 8'h28, 32'h34);
        entry(15'h1, 8'h28, 32'h33);
        entry(15'h2, 8'h28, 32'h40);
        entry(15'h3, 8'h28, 32'h41);
        rcb_host_i.wr_reg(8'h08, 32'h1);
        rcb_host_i.wr_reg(8'h04, {30'h0, rcb_pkg::always_mode});
        rcb_host_i.wr_reg(8'h00, 32'h3);
        feed(1'b1, 5, 32'h50);
        chk("always on", 32'h1, {31'h0, storing});
        rcb_host_i.wr_reg(8'h00, 32'h4);
        entry(15'h0, 8'h28, 32'h54);
        entry(15'h3, 8'h30, 32'h0);
        rdchk("compact used", 8'h20, 32'h10);
        rdchk("compact avail", 8'h1c, 32'h1d4b0);
        wrap_up();
    end
endmodule : test_reading_capture_buffer
